// ---- fault_pkg.sv ----
// Shared constants and carriers of the gate driver fault manager.
// Assumes a 100 MHz core clock; all intervals are derived from it.
package fault_pkg;

    // =====================================================================
    // Clock and interval constants
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned REPORT_US     = 56;
    localparam int unsigned REPORT_CYC    = REPORT_US * CLK_MHZ;
    localparam int unsigned DEAD_MIN_NS   = 40;
    localparam int unsigned DEAD_STEP_NS  = 40;
    localparam int unsigned BLANK_NS [4]  = '{500, 1000, 2000, 4000};
    localparam int unsigned FILT_NS  [4]  = '{250, 500, 1000, 2000};
    localparam int unsigned DRIVE_NS [4]  = '{250, 500, 1000, 2000};

    // Least time in ns to whole cycles, rounded up, never below one
    function automatic logic [15:0] ns2cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return 16'(c);
    endfunction

    localparam logic [15:0] DEAD_MIN_CYC  = ns2cyc(DEAD_MIN_NS);
    localparam logic [15:0] DEAD_STEP_CYC = ns2cyc(DEAD_STEP_NS);
    localparam logic [15:0] BLANK_CYC [4] = '{ns2cyc(BLANK_NS[0]), ns2cyc(BLANK_NS[1]),
                                              ns2cyc(BLANK_NS[2]), ns2cyc(BLANK_NS[3])};
    localparam logic [15:0] FILT_CYC  [4] = '{ns2cyc(FILT_NS[0]), ns2cyc(FILT_NS[1]),
                                              ns2cyc(FILT_NS[2]), ns2cyc(FILT_NS[3])};
    localparam logic [15:0] DRIVE_CYC [4] = '{ns2cyc(DRIVE_NS[0]), ns2cyc(DRIVE_NS[1]),
                                              ns2cyc(DRIVE_NS[2]), ns2cyc(DRIVE_NS[3])};

    // =====================================================================
    // Overcurrent response encodings
    localparam logic [2:0] OC_LATCH  = 3'h0;
    localparam logic [2:0] OC_REPORT = 3'h1;
    localparam logic [2:0] OC_OFF    = 3'h2;

    // =====================================================================
    // Carriers
    typedef struct packed {
        logic [5:0] pwm_cmd;
        logic [5:0] gate_fb;
        logic [5:0] ds_trip;
        logic [2:0] src_trip;
        logic [3:0] warn;
        logic [4:0] fault;
        logic [3:0] thermal;
        logic       wd;
        logic       reg_low;
        logic       gate_enable;
    } sense_t;

    typedef struct packed {
        logic [2:0] dead_time_sel;
        logic [1:0] oc_mask_interval_sel;
        logic [1:0] oc_filter_interval_sel;
        logic [4:0] drain_source_trip_level;
        logic [2:0] oc_response_sel;
        logic [1:0] sink_drive_timer_sel;
        logic [1:0] source_drive_timer_sel;
        logic       gate_check_disable;
    } cfg_t;

    typedef struct packed {
        logic [3:0] warn;
        logic       fault_summary;
        logic [4:0] supply_fault;
        logic [5:0] ds_oc;
        logic [2:0] src_oc;
        logic [5:0] fet_gate_mismatch;
        logic       watchdog_expired_fault;
        logic       reg_fault;
        logic [3:0] thermal;
        logic       clear_faults;
    } status_t;

endpackage

// ---- gate_driver_fault_manager.sv ----
// Fault classification, warning/fault reporting, dead time, drain-source
// overcurrent timing and gate output checking for three half-bridges.
// Assumes analog comparator and pin inputs are asynchronous; cfg, the clear
// write strobe and the status read strobe come from register logic on clk.
//
// Contract
// RULE_01: Warning sets status, toggles fault line 56us.
// RULE_02: Status read stops toggling; bit follows condition.
// RULE_03: Re-toggle only after condition clears and returns.
// RULE_04: Fault holds line low, sets summary bit.
// RULE_05: Faults latch, shut driver until recovery.
// RULE_06: Fault pulls every gate output low.
// RULE_07: Fault overrides an active warning report.
// RULE_08: Host removes condition, then clears or pulses enable.
// RULE_09: Clear bit self-resets; fault line released.
// RULE_10: Thermal flags real time, never touch line.
// RULE_11: Watchdog or regulator fault also drops power good.
// RULE_12: Opposite gate waits for cutoff comparator.
// RULE_13: Dead time 40ns plus selected extension.
// RULE_14: Trip level follows setting, even while running.
// RULE_15: Blank overcurrent comparators after each turn-on.
// RULE_16: Trip must persist for the deglitch interval.
// RULE_17: Response chosen: latch, report, or disabled.
// RULE_18: Latch response: all gates low, fault latched.
// RULE_19: Report only keeps gates; disabled ignores trips.
// RULE_20: Drive timer expiry compares gate with command.
// RULE_21: Source sense trip latches fault, gates off.
// RULE_22: Each condition gets its gate/report action.
// RULE_23: Gate check disable suppresses mismatch faults.
// RULE_24: Intervals come from restartable clock counters.
`timescale 1ns/1ps

module gate_driver_fault_manager #(
    parameter int unsigned REPORT_CYC = fault_pkg::REPORT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire fault_pkg::sense_t sense_in,
    input  wire fault_pkg::cfg_t   cfg,
    input  wire logic              clear_faults_wr,
    input  wire logic              warn_status_read,
    output logic [5:0]             gate_out,
    output logic                   fault_out_n_o,
    output logic                   fault_out_n_oe,
    output logic                   power_good_out,
    output logic [4:0]             trip_level_out,
    output fault_pkg::status_t     status
);

    // =====================================================================
    // Input synchronisers
    fault_pkg::sense_t s1_q;
    fault_pkg::sense_t s_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= '0;
            s_q  <= '0;
        end else begin
            s1_q <= sense_in;
            s_q  <= s1_q;
        end
    end

    // =====================================================================
    // Configuration decode
    wire oc_latch  = (cfg.oc_response_sel == fault_pkg::OC_LATCH);     // RULE_17
    wire oc_report = (cfg.oc_response_sel == fault_pkg::OC_REPORT);    // RULE_17
    wire oc_off    = ~oc_latch & ~oc_report;
    wire [15:0] dead_cyc  = fault_pkg::DEAD_MIN_CYC +
                            16'(cfg.dead_time_sel) * fault_pkg::DEAD_STEP_CYC;  // RULE_13
    wire [15:0] blank_cyc = fault_pkg::BLANK_CYC[cfg.oc_mask_interval_sel];
    wire [15:0] filt_cyc  = fault_pkg::FILT_CYC[cfg.oc_filter_interval_sel];

    logic [5:0]         gate_q;
    logic [5:0]         gate_d;
    logic [5:0]         ds_evt;
    logic [5:0]         gm_evt;
    logic               fault_any_d;
    fault_pkg::status_t status_q;

    // =====================================================================
    // Per-FET gate sequencing and monitors; even index is high side
    for (genvar i = 0; i < 6; i++) begin : g_fet
        localparam int unsigned OPP = i ^ 1;
        logic [15:0] dt_q;
        logic [15:0] blank_q;
        logic [15:0] glitch_q;
        logic [15:0] drv_q;
        wire  [15:0] drv_cyc = (i % 2 == 0) ?
                               fault_pkg::DRIVE_CYC[cfg.sink_drive_timer_sel] :
                               fault_pkg::DRIVE_CYC[cfg.source_drive_timer_sel];
        wire want    = s_q.pwm_cmd[i] & ~s_q.pwm_cmd[OPP] & s_q.gate_enable;
        wire opp_off = ~s_q.gate_fb[OPP] & ~gate_q[OPP];                 // RULE_12
        wire dt_done = (dt_q >= dead_cyc);                                // RULE_13
        wire watch   = gate_q[i] & (blank_q == 16'h0000);                 // RULE_15
        wire trip    = watch & s_q.ds_trip[i];

        assign gate_d[i] = want & opp_off & dt_done & ~fault_any_d;       // RULE_06
        assign ds_evt[i] = trip & (glitch_q >= filt_cyc);                 // RULE_16
        assign gm_evt[i] = (drv_q == 16'h0001) & (s_q.gate_fb[i] != gate_q[i])
                           & ~cfg.gate_check_disable;                     // RULE_20

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                dt_q     <= 16'h0000;
                blank_q  <= 16'h0000;
                glitch_q <= 16'h0000;
                drv_q    <= 16'h0000;
            end else begin
                dt_q     <= !(want & opp_off) ? 16'h0000 :
                            dt_done ? dt_q : dt_q + 16'h0001;             // RULE_24
                blank_q  <= (gate_d[i] & ~gate_q[i]) ? blank_cyc :
                            (blank_q != 16'h0000) ? blank_q - 16'h0001 : 16'h0000;
                glitch_q <= !trip ? 16'h0000 :
                            (glitch_q >= filt_cyc) ? glitch_q : glitch_q + 16'h0001;
                drv_q    <= (gate_d[i] != gate_q[i]) ? drv_cyc :
                            (drv_q != 16'h0000) ? drv_q - 16'h0001 : 16'h0000;
            end
        end
    end

    // =====================================================================
    // Fault latches and recovery
    logic clr_pend_q;
    wire cond_gone = ~|s_q.fault & ~|s_q.src_trip & ~|s_q.ds_trip & ~s_q.wd & ~s_q.reg_low;
    wire clr_req   = (clr_pend_q | ~s_q.gate_enable) & cond_gone;         // RULE_08
    wire keep      = ~clr_req;
    wire [5:0] ds_use = ds_evt & {6{~oc_off}};                            // RULE_19

    logic [4:0] sup_d;
    logic [2:0] src_d;
    logic [5:0] gm_d;
    logic [5:0] dsoc_d;
    logic       dsf_q;
    logic       dsf_d;
    logic       wd_d;
    logic       rg_d;

    assign sup_d  = s_q.fault | (status_q.supply_fault & {5{keep}});      // RULE_05
    assign src_d  = s_q.src_trip | (status_q.src_oc & {3{keep}});         // RULE_21
    assign gm_d   = gm_evt | (status_q.fet_gate_mismatch & {6{keep}});    // RULE_23
    assign dsoc_d = ds_use | (status_q.ds_oc & {6{keep}});                // RULE_18
    assign dsf_d  = (oc_latch & |ds_evt) | (dsf_q & keep);                // RULE_18
    assign wd_d   = s_q.wd | (status_q.watchdog_expired_fault & keep);                  // RULE_11
    assign rg_d   = s_q.reg_low | (status_q.reg_fault & keep);            // RULE_11
    assign fault_any_d = |sup_d | |src_d | |gm_d | dsf_d | wd_d | rg_d;   // RULE_22

    // =====================================================================
    // Warning report: edge armed, read disarmed, toggled at 56 us
    logic [4:0]  warn_prev_q;
    logic [4:0]  rep_q;
    logic [15:0] tog_q;
    logic        phase_q;
    wire  [4:0]  warn_src  = {oc_report & |ds_evt, s_q.warn};             // RULE_19
    wire  [4:0]  warn_rise = warn_src & ~warn_prev_q;                     // RULE_03
    wire  [4:0]  rep_d     = warn_rise | (rep_q & {5{~warn_status_read}}); // RULE_02
    wire         warn_on   = |rep_q & ~fault_any_d;                        // RULE_07
    wire         tog_end   = (tog_q == 16'(REPORT_CYC - 1));
    wire         line_low  = fault_any_d | (warn_on & ~phase_q);           // RULE_04

    // =====================================================================
    // Power good: 56 us minimum low on watchdog or regulator fault
    logic        wd_prev_q;
    logic        rg_prev_q;
    logic [15:0] pg_q;
    wire         pg_start = (s_q.wd & ~wd_prev_q) | (s_q.reg_low & ~rg_prev_q);
    wire  [15:0] pg_d     = pg_start ? 16'(REPORT_CYC) :
                            (pg_q != 16'h0000) ? pg_q - 16'h0001 : 16'h0000;   // RULE_24

    fault_pkg::status_t status_d;
    always_comb begin
        status_d                   = '0;
        status_d.warn              = s_q.warn;                            // RULE_02
        status_d.fault_summary     = fault_any_d;                         // RULE_04
        status_d.supply_fault      = sup_d;
        status_d.ds_oc             = dsoc_d;
        status_d.src_oc            = src_d;
        status_d.fet_gate_mismatch = gm_d;
        status_d.watchdog_expired_fault          = wd_d;
        status_d.reg_fault         = rg_d;
        status_d.thermal           = s_q.thermal;                         // RULE_10
        status_d.clear_faults      = clear_faults_wr | (clr_pend_q & ~clr_req);  // RULE_09
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_q         <= 6'h00;
            dsf_q          <= 1'b0;
            clr_pend_q     <= 1'b0;
            status_q       <= '0;
            warn_prev_q    <= 5'h00;
            rep_q          <= 5'h00;
            tog_q          <= 16'h0000;
            phase_q        <= 1'b0;
            fault_out_n_oe <= 1'b0;
            fault_out_n_o  <= 1'b0;
            wd_prev_q      <= 1'b0;
            rg_prev_q      <= 1'b0;
            pg_q           <= 16'h0000;
            power_good_out <= 1'b1;
            trip_level_out <= 5'h00;
        end else begin
            gate_q         <= gate_d;
            dsf_q          <= dsf_d;
            clr_pend_q     <= status_d.clear_faults;                      // RULE_09
            status_q       <= status_d;
            warn_prev_q    <= warn_src;
            rep_q          <= rep_d;
            tog_q          <= (!warn_on || tog_end) ? 16'h0000 : tog_q + 16'h0001;  // RULE_01
            phase_q        <= warn_on & (phase_q ^ tog_end);              // RULE_01
            fault_out_n_oe <= line_low;                                   // RULE_04
            fault_out_n_o  <= 1'b0;
            wd_prev_q      <= s_q.wd;
            rg_prev_q      <= s_q.reg_low;
            pg_q           <= pg_d;
            power_good_out <= (pg_d == 16'h0000) & ~s_q.reg_low;          // RULE_11
            trip_level_out <= cfg.drain_source_trip_level;                // RULE_14
        end
    end

    assign gate_out = gate_q;
    assign status   = status_q;

    // =====================================================================
    // Checks
    AST_WARN_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)  // RULE_01
        (warn_on && tog_end && !fault_any_d && $stable(rep_q))
        |=> (fault_out_n_oe == !$past(phase_q)))
        else $error("warning report did not change phase at interval end");

    AST_READ_DISARMS: assert property (@(posedge clk) disable iff (!rstn)  // RULE_02
        (warn_status_read && warn_rise == 5'h00) |=> (rep_q == 5'h00))
        else $error("status read did not stop the warning report");

    AST_NO_REARM: assert property (@(posedge clk) disable iff (!rstn)  // RULE_03
        ##1 ((rep_q & ~$past(rep_q)) & ~$past(warn_rise)) == 5'h00)
        else $error("warning report armed without a new condition edge");

    AST_FAULT_LINE: assert property (@(posedge clk) disable iff (!rstn)  // RULE_04
        status_q.fault_summary |-> (fault_out_n_oe && gate_q == 6'h00))
        else $error("fault present but line released or gates driven");

    AST_CLEAR_SELF: assert property (@(posedge clk) disable iff (!rstn)  // RULE_09
        (clr_req && !clear_faults_wr && !fault_any_d)
        |=> (!status_q.clear_faults ##1
             (!fault_out_n_oe || $past(warn_on) || $past(fault_any_d))))
        else $error("clear bit or fault line not released after recovery");

    AST_PG_LOW: assert property (@(posedge clk) disable iff (!rstn)  // RULE_11
        (s_q.wd && !wd_prev_q) |=> !power_good_out [*8])
        else $error("power good not held low after watchdog fault");

    AST_DEAD_TIME: assert property (@(posedge clk) disable iff (!rstn)  // RULE_13
        $rose(gate_q[0]) |-> ($past(~gate_q[1] & ~s_q.gate_fb[1], 2) &&
                              $past(~gate_q[1] & ~s_q.gate_fb[1], 5)))
        else $error("high side enabled before low side cutoff and dead time");

    AST_BLANKING: assert property (@(posedge clk) disable iff (!rstn)  // RULE_15
        $rose(gate_q[0]) |-> (ds_evt[0] == 1'b0) [*8])
        else $error("overcurrent seen inside the blanking interval");

    AST_DEGLITCH: assert property (@(posedge clk) disable iff (!rstn)  // RULE_16
        ds_evt[0] |-> ($past(s_q.ds_trip[0]) && $past(s_q.ds_trip[0], 8)))
        else $error("overcurrent event from a trip shorter than the filter");

    AST_OC_DISABLED: assert property (@(posedge clk) disable iff (!rstn)  // RULE_19
        oc_off |=> ((status_q.ds_oc & ~$past(status_q.ds_oc)) == 6'h00))
        else $error("overcurrent reported while response is disabled");

    AST_SRC_TRIP: assert property (@(posedge clk) disable iff (!rstn)  // RULE_21
        (s_q.src_trip != 3'h0) |=> (status_q.fault_summary && gate_q == 6'h00))
        else $error("source sense trip did not latch a fault");

endmodule

// ---- host_model.sv ----
// Host microcontroller as seen by the fault manager: register strobes and
// the pulled-up open-drain fault line.
// Assumes strobes are sampled by the block on the rising edge of clk.
`timescale 1ns/1ps

module host_model (
    input  wire logic clk,
    input  wire logic fault_out_n_o,
    input  wire logic fault_out_n_oe,
    output logic      clear_faults_wr,
    output logic      warn_status_read,
    output wire logic fault_line_n
);
    // =====================================================================
    // External pull-up: the line floats high when released
    assign fault_line_n = fault_out_n_oe ? fault_out_n_o : 1'b1;

    initial begin
        clear_faults_wr  = 1'b0;
        warn_status_read = 1'b0;
    end

    // =====================================================================
    // One-cycle write of 1 to the clear bit, whether or not the condition is gone
    task automatic write_clear();
        @(posedge clk);
        clear_faults_wr <= 1'b1;
        @(posedge clk);
        clear_faults_wr <= 1'b0;
    endtask

    // One-cycle read of the warning status register
    task automatic read_status();
        @(posedge clk);
        warn_status_read <= 1'b1;
        @(posedge clk);
        warn_status_read <= 1'b0;
    endtask
endmodule

// ---- gate_driver_fault_manager_tb.sv ----
// Self-checking bench of the gate driver fault manager.
// Assumes the host model above and a short report interval parameter.
`timescale 1ns/1ps

module gate_driver_fault_manager_tb;
    localparam int RC = 16;
    logic clk, rstn, clr_wr, rd_str, fault_o, fault_oe, pg, fault_line_n;
    logic [5:0] gate_out;
    logic [4:0] trip_lvl;
    fault_pkg::sense_t  sense;
    fault_pkg::cfg_t    cfg;
    fault_pkg::status_t status;
    int fails, tests_run, cycles, n, w, f, d;
    logic [4:0] lvl;

    gate_driver_fault_manager #(.REPORT_CYC(RC)) gate_driver_fault_manager_i (
        .clk(clk), .rstn(rstn), .sense_in(sense), .cfg(cfg), .clear_faults_wr(clr_wr),
        .warn_status_read(rd_str), .gate_out(gate_out), .fault_out_n_o(fault_o),
        .fault_out_n_oe(fault_oe), .power_good_out(pg), .trip_level_out(trip_lvl),
        .status(status));
    host_model host_model_i (.clk(clk), .fault_out_n_o(fault_o), .fault_out_n_oe(fault_oe),
        .clear_faults_wr(clr_wr), .warn_status_read(rd_str), .fault_line_n(fault_line_n));

    // =====================================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    function automatic logic probe(input int s);
        return s == 0 ? fault_line_n : (s == 1 ? pg : gate_out[0]);
    endfunction
    // Cycles until the probed signal reaches v, bounded at 300
    task automatic span(input int s, input logic v, output int c);
        c = 0;
        while (probe(s) !== v && c < 300) begin
            c++;
            @(posedge clk);
        end
    endtask
    // Probed signal must stay at v for c cycles
    task automatic hold(input string nm, input int s, input logic v, input int c);
        int bad;
        bad = 0;
        repeat (c) begin
            @(posedge clk);
            bad += int'(probe(s) !== v);
        end
        chk(nm, bad, 0);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic oc_run(input logic [2:0] m);
        int c;
        cfg.oc_response_sel <= m;
        sense.pwm_cmd <= 6'h00;
        sense.gate_fb <= 6'h00;
        cyc(10);
        sense.pwm_cmd <= 6'h01;
        sense.gate_fb <= 6'h01;
        span(2, 1'b1, c);
        sense.ds_trip[0] <= 1'b1;
        cyc(40);
        sense.ds_trip[0] <= 1'b0;
        cyc(20);
        chk("blank", status.ds_oc, 32'h0);
        sense.ds_trip[0] <= 1'b1;
        cyc(10);
        sense.ds_trip[0] <= 1'b0;
        cyc(30);
        chk("glitch", status.ds_oc, 32'h0);
        sense.ds_trip[0] <= 1'b1;
        cyc(40);
        chk("oc flag", status.ds_oc, m == fault_pkg::OC_OFF ? 32'h0 : 32'h1);
        chk("oc gate", gate_out[0], m != fault_pkg::OC_LATCH);
        chk("oc summary", status.fault_summary, m == fault_pkg::OC_LATCH);
        sense.ds_trip[0] <= 1'b0;
        host_model_i.read_status();
        host_model_i.write_clear();
        cyc(8);
    endtask

    // =====================================================================
    // Clock, timeout, main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        rstn = 1'b0;
        sense = '0;
        cfg = '0;
        sense.gate_enable = 1'b1;
        void'($urandom(32'hE9C50CE4));
        cyc(2);
        rstn <= 1'b1;
        chk("reset status", status, 32'h0);
        chk("reset pg", pg, 1'b1);
        cyc(4);
        sense.thermal <= 4'($urandom);
        lvl = 5'($urandom);
        cfg.drain_source_trip_level <= lvl;
        hold("thermal line", 0, 1'b1, 3 * RC);
        chk("thermal", status.thermal, sense.thermal);
        chk("trip level", trip_lvl, lvl);
        d = $urandom % 8;
        cfg.dead_time_sel <= 3'(d);
        sense.gate_fb <= 6'h02;
        sense.pwm_cmd <= 6'h01;
        hold("handshake", 2, 1'b0, 20);
        sense.gate_fb <= 6'h01;
        span(2, 1'b1, n);
        d = fault_pkg::DEAD_MIN_CYC + d * fault_pkg::DEAD_STEP_CYC;
        chk("dead time", n > d && n <= d + 8, 1'b1);
        cfg.gate_check_disable <= 1'b1;
        sense.pwm_cmd <= 6'h00;
        cyc(60);
        chk("check off", status.fet_gate_mismatch, 32'h0);
        cfg.gate_check_disable <= 1'b0;
        sense.gate_fb <= 6'h00;
        sense.pwm_cmd <= 6'h01;
        cyc(80);
        chk("mismatch", status.fet_gate_mismatch, 32'h1);
        chk("mismatch gate", gate_out, 32'h0);
        chk("mismatch line", fault_line_n, 1'b0);
        sense.pwm_cmd <= 6'h00;
        cfg.gate_check_disable <= 1'b1;
        host_model_i.write_clear();
        cyc(6);
        chk("mismatch clear", status.fault_summary, 1'b0);
        w = $urandom % 4;
        sense.warn[w] <= 1'b1;
        span(0, 1'b0, n);
        span(0, 1'b1, n);
        chk("warn low", n, RC);
        span(0, 1'b0, n);
        chk("warn high", n, RC);
        chk("warn bit", status.warn[w], 1'b1);
        host_model_i.read_status();
        cyc(4);
        hold("read stops", 0, 1'b1, 3 * RC);
        chk("warn kept", status.warn[w], 1'b1);
        sense.warn[w] <= 1'b0;
        cyc(6);
        chk("warn gone", status.warn[w], 1'b0);
        sense.warn[w] <= 1'b1;
        span(0, 1'b0, n);
        chk("rearm", n < 8, 1'b1);
        f = $urandom % 5;
        sense.fault[f] <= 1'b1;
        cyc(4);
        hold("fault over warn", 0, 1'b0, 3 * RC);
        chk("summary", status.fault_summary, 1'b1);
        chk("fault type", status.supply_fault[f], 1'b1);
        host_model_i.write_clear();
        cyc(3);
        chk("clear pending", status.clear_faults, 1'b1);
        chk("still latched", status.fault_summary, 1'b1);
        sense.fault <= '0;
        sense.warn <= '0;
        host_model_i.read_status();
        cyc(8);
        chk("clear self", status.clear_faults, 1'b0);
        chk("released", fault_line_n, 1'b1);
        f = $urandom % 3;
        sense.pwm_cmd <= 6'h01;
        sense.gate_fb <= 6'h01;
        span(2, 1'b1, n);
        sense.src_trip[f] <= 1'b1;
        cyc(5);
        chk("src gate", gate_out, 32'h0);
        chk("src flag", status.src_oc[f], 1'b1);
        sense.src_trip <= '0;
        sense.gate_enable <= 1'b0;
        cyc(5);
        sense.gate_enable <= 1'b1;
        cyc(6);
        chk("enable pulse", fault_line_n, 1'b1);
        for (int m = 0; m < 3; m++) begin
            oc_run(3'(m));
        end
        sense.wd <= 1'b1;
        cyc(4);
        span(1, 1'b1, n);
        chk("wd pg", n >= RC - 4 && n <= RC + 4, 1'b1);
        chk("wd flag", status.watchdog_expired_fault, 1'b1);
        chk("wd line", fault_line_n, 1'b0);
        print_verdict();
    end
endmodule
